// File: sbs_pkg.sv
// Package for the sensor bring-up sequencer: register map, fields, states,
// timing constants and the serial write carrier.
// Assumes a single 20 MHz clock domain shared by every file that imports it.
package sbs_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned RST_WAIT_NS     = 10000;
	// Least time: round up to whole cycles
	localparam int unsigned RST_WAIT_CYC    = (RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_WAIT_W      = $clog2(RST_WAIT_CYC + 1);

	// ==========================================================
	// Register map
	localparam int unsigned ADDR_W          = 9;
	localparam int unsigned DATA_W          = 16;
	localparam int unsigned NREG            = 22;
	localparam logic [ADDR_W-1:0] ADDR_VARIANT   = 9'h002;
	localparam logic [ADDR_W-1:0] ADDR_CLK_MGMT  = 9'h020;
	localparam logic [ADDR_W-1:0] ADDR_LOGIC_EN  = 9'h022;
	localparam logic [ADDR_W-1:0] ADDR_COL_MUX   = 9'h028;
	localparam logic [ADDR_W-1:0] ADDR_FRONT_END = 9'h030;
	localparam logic [ADDR_W-1:0] ADDR_BIAS_EN   = 9'h040;
	localparam logic [ADDR_W-1:0] ADDR_TX_EN     = 9'h070;
	localparam logic [ADDR_W-1:0] ADDR_DEPTH     = 9'h081;
	localparam logic [ADDR_W-1:0] ADDR_SEQ_MODE  = 9'h0C0;
	// Standby (1) write window: addresses below this one
	localparam logic [ADDR_W-1:0] ADDR_STBY1_LIM = 9'h028;
	localparam logic [ADDR_W-1:0] REG_ADDR [NREG] = '{
		9'h002, 9'h020, 9'h022, 9'h028, 9'h030, 9'h040, 9'h041, 9'h042,
		9'h043, 9'h044, 9'h070, 9'h080, 9'h081, 9'h0C0, 9'h0CC, 9'h0E0,
		9'h0E1, 9'h100, 9'h101, 9'h102, 9'h1BF, 9'h1C0};
	// Registers whose upload leads from intermediate standby to standby (2)
	localparam logic [NREG-1:0] RESERVED_MASK = 22'h3F_DBC0;

	// ==========================================================
	// Fields and reset value
	localparam int unsigned BIT_ENABLE      = 0;
	localparam int unsigned BIT_COL_MUX_HI  = 1;
	localparam int unsigned BIT_DEPTH_8     = 13;
	localparam int unsigned OVH_LSB         = 2;
	localparam int unsigned OVH_MSB         = 3;
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
	localparam logic [1:0]  OVH_ZERO        = 2'h3;

	// ==========================================================
	// Serial frame: address, write flag, data
	localparam int unsigned SPI_FRAME_BITS  = ADDR_W + 1 + DATA_W;
	localparam int unsigned SPI_HDR_BITS    = ADDR_W + 1;
	localparam int unsigned SPI_CNT_W       = $clog2(SPI_FRAME_BITS + 1);

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} sbs_wr_t;

	typedef enum logic [2:0] {
		ST_STBY1,
		ST_INTER,
		ST_STBY2,
		ST_IDLE,
		ST_RUN
	} sbs_state_t;

endpackage

// File: sbs_spi_slave.sv
// Serial register port of the sensor: frames a 26-bit word into a write
// request, or answers a read with the addressed register.
// Assumes serial pins synchronous to clk_i and sck far slower than clk_i.
`timescale 1ns/1ps
`default_nettype none
module sbs_spi_slave
	import sbs_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              ce_i,
	input  wire logic              spi_cs_n_i,
	input  wire logic              spi_sck_i,
	input  wire logic              spi_mosi_i,
	output logic                   spi_miso_o,
	output logic [ADDR_W-1:0]      rd_addr_o,
	input  wire logic [DATA_W-1:0] rd_data_i,
	output logic                   wr_valid_o,
	output sbs_wr_t                wr_o
);
	// ==========================================================
	// Edge detection and framing
	logic                        sck_q;
	logic [SPI_CNT_W-1:0]        cnt_q;
	logic [SPI_FRAME_BITS-1:0]   sh_q;
	logic [DATA_W-1:0]           out_q;
	wire                         rise      = spi_sck_i & ~sck_q & ~spi_cs_n_i;
	wire                         fall      = ~spi_sck_i & sck_q & ~spi_cs_n_i;
	wire [SPI_FRAME_BITS-1:0]    sh_next   = {sh_q[SPI_FRAME_BITS-2:0], spi_mosi_i};
	wire                         hdr_done  = rise && (cnt_q == SPI_CNT_W'(SPI_HDR_BITS - 1));
	wire                         frame_end = rise && (cnt_q == SPI_CNT_W'(SPI_FRAME_BITS - 1));

	// Address becomes known once the header has been shifted in
	assign rd_addr_o = sh_next[ADDR_W:1];

	// Shifter; chip select high aborts a partial frame
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sck_q      <= 1'b0;
			cnt_q      <= '0;
			sh_q       <= '0;
			out_q      <= '0;
			spi_miso_o <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_o       <= '0;
		end else if (ce_i) begin
			sck_q      <= spi_sck_i;
			wr_valid_o <= 1'b0;
			if (spi_cs_n_i) begin
				cnt_q <= '0;
			end else if (rise) begin
				sh_q  <= sh_next;
				cnt_q <= frame_end ? '0 : cnt_q + 1'b1;
			end
			if (hdr_done) begin
				out_q <= rd_data_i; // Read data latched at the header end
			end else if (fall) begin
				spi_miso_o <= out_q[DATA_W-1];
				out_q      <= {out_q[DATA_W-2:0], 1'b0};
			end
			// Write only when the header's write flag was set
			if (frame_end && sh_next[DATA_W]) begin
				wr_valid_o <= 1'b1;
				wr_o       <= '{addr: sh_next[SPI_FRAME_BITS-1:DATA_W+1], data: sh_next[DATA_W-1:0]};
			end
		end
	end
endmodule
`default_nettype wire

// File: sbs_core.sv
// Bring-up state logic of the image sensor: register file, standby, idle
// and running states, with write gating per state.
// Assumes rstn_i is the sensor's hard reset pin and the clock runs first.
//
// What this block and its host do
// RULE1 - Host changes state only by serial writes
// RULE2 - Mode reconfiguration never changes power state
// RULE3 - Host starts clock before releasing hard reset
// RULE4 - Hard reset release enters standby one
// RULE5 - Uploads accepted only ten microseconds after reset
// RULE6 - Host clock matches word depth bit
// RULE7 - Host enables clock management in order
// RULE8 - Host writes reserved bias and gain values
// RULE9 - Host programs black calibration register
// RULE10 - Host writes dummy row and latency registers
// RULE11 - Host uploads sequencer and window registers
// RULE12 - Host soft power-up writes in order
// RULE13 - Host enables sequencer with row-overhead setting
// RULE14 - Enabled sequencer makes sensor acquire continuously
// RULE15 - Standby one accepts writes below forty only
// RULE16 - Standby two: all registers accessible, blocks off
// RULE17 - Sequencer register selects row overhead, enable
// RULE18 - Host waits for each write to finish
// RULE19 - Host picks table values from configuration
`timescale 1ns/1ps
`default_nettype none
module sbs_core
	import sbs_pkg::*;
#(
	parameter int unsigned WAIT_CYC = RST_WAIT_CYC
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic ce_i,
	input  wire logic spi_cs_n_i,
	input  wire logic spi_sck_i,
	input  wire logic spi_mosi_i,
	output logic      spi_miso_o,
	output sbs_state_t state_o,
	output logic      acquiring_o,
	output logic      blocks_enabled_o,
	output logic [1:0] row_overhead_time_o,
	output logic      zero_row_overhead_mode_o,
	output logic      word_depth_8bit_o
);
	// ==========================================================
	// Serial port
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic              wr_valid;
	sbs_wr_t           wr;

	sbs_spi_slave u_sbs_spi_slave (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.spi_cs_n_i (spi_cs_n_i),
		.spi_sck_i  (spi_sck_i),
		.spi_mosi_i (spi_mosi_i),
		.spi_miso_o (spi_miso_o),
		.rd_addr_o  (rd_addr),
		.rd_data_i  (rd_data),
		.wr_valid_o (wr_valid),
		.wr_o       (wr)
	);

	// ==========================================================
	// Decoding
	function automatic logic [NREG-1:0] reg_hit(input logic [ADDR_W-1:0] a);
		logic [NREG-1:0] h;
		h = '0;
		for (int k = 0; k < NREG; k++) begin
			h[k] = (a == REG_ADDR[k]);
		end
		return h;
	endfunction

	sbs_state_t                 state_q;
	sbs_state_t                 state_d;
	logic [RST_WAIT_W-1:0]      wait_q;
	logic [DATA_W-1:0]          regs_q [NREG];
	logic [NREG-1:0]            written_q;
	logic [NREG-1:0]            rd_hit;
	logic [NREG-1:0]            wr_hit;

	assign rd_hit = reg_hit(rd_addr);
	assign wr_hit = reg_hit(wr.addr);

	// Cheap ceiling on early writes, one counter rather than a timer block
	wire wait_done = (wait_q == RST_WAIT_W'(WAIT_CYC));
	wire in_stby1  = (state_q == ST_STBY1);
	// Standby one opens only the low register range, and only after the wait
	wire wr_ok     = wr_valid && wait_done && (!in_stby1 || wr.addr < ADDR_STBY1_LIM); // RULE5 RULE15
	wire [NREG-1:0] wr_en = wr_ok ? wr_hit : '0;
	wire seq_wr    = wr_ok && (wr.addr == ADDR_SEQ_MODE);

	// Register views; the array element is an operand, so each view follows its register
	function automatic int unsigned reg_idx(input logic [ADDR_W-1:0] a);
		int unsigned n;
		n = 0;
		for (int unsigned k = 0; k < NREG; k++) begin
			if (REG_ADDR[k] == a) n = k;
		end
		return n;
	endfunction

	wire [DATA_W-1:0] clk_mgmt  = regs_q[reg_idx(ADDR_CLK_MGMT)];
	wire [DATA_W-1:0] logic_en  = regs_q[reg_idx(ADDR_LOGIC_EN)];
	wire [DATA_W-1:0] col_mux   = regs_q[reg_idx(ADDR_COL_MUX)];
	wire [DATA_W-1:0] front_end = regs_q[reg_idx(ADDR_FRONT_END)];
	wire [DATA_W-1:0] bias_en   = regs_q[reg_idx(ADDR_BIAS_EN)];
	wire [DATA_W-1:0] tx_en     = regs_q[reg_idx(ADDR_TX_EN)];
	wire [DATA_W-1:0] seq_mode  = regs_q[reg_idx(ADDR_SEQ_MODE)];
	wire [DATA_W-1:0] depth     = regs_q[reg_idx(ADDR_DEPTH)];

	// Soft power-up complete: every block enable set
	wire powered = clk_mgmt[BIT_ENABLE] && bias_en[BIT_ENABLE] && col_mux[BIT_ENABLE]
	             && col_mux[BIT_COL_MUX_HI] && front_end[BIT_ENABLE] && tx_en[BIT_ENABLE];
	wire seq_on   = seq_mode[BIT_ENABLE];
	wire uploaded = ((written_q & RESERVED_MASK) == RESERVED_MASK);
	wire logic_on = logic_en[BIT_ENABLE];

	// Every register readable; unmapped addresses read zero
	always_comb begin
		rd_data = REG_RESET;
		for (int k = 0; k < NREG; k++) begin
			if (rd_hit[k]) rd_data = regs_q[k]; // RULE16
		end
	end

	// ==========================================================
	// Register file
	for (genvar g = 0; g < NREG; g++) begin : g_reg
		always_ff @(posedge clk_i) begin
			if (!rstn_i) begin
				regs_q[g]    <= REG_RESET;
				written_q[g] <= 1'b0;
			end else if (ce_i && wr_en[g]) begin
				regs_q[g]    <= wr.data;
				written_q[g] <= 1'b1;
			end
		end
	end

	// Post-reset wait counter, saturating
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wait_q <= '0;
		end else if (ce_i && !wait_done) begin
			wait_q <= wait_q + 1'b1;
		end
	end

	// ==========================================================
	// State transitions follow enable bits and upload completion only, so mode fields never move them
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_STBY1: if (logic_on) state_d = ST_INTER;
			ST_INTER: if (uploaded) state_d = ST_STBY2;
			ST_STBY2: if (powered) state_d = ST_IDLE; // RULE16
			ST_IDLE: begin
				if (!powered) state_d = ST_STBY2;
				else if (seq_on) state_d = ST_RUN;
			end
			ST_RUN: begin
				if (!powered) state_d = ST_STBY2;
				else if (!seq_on) state_d = ST_IDLE; // RULE2
			end
			default: state_d = ST_STBY1;
		endcase
	end

	// State and registered outputs
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q                  <= ST_STBY1; // RULE4
			acquiring_o              <= 1'b0;
			blocks_enabled_o         <= 1'b0;
			row_overhead_time_o      <= 2'h0;
			zero_row_overhead_mode_o <= 1'b0;
			word_depth_8bit_o        <= 1'b0;
		end else if (ce_i) begin
			state_q                  <= state_d;
			acquiring_o              <= (state_d == ST_RUN); // RULE14
			blocks_enabled_o         <= (state_d == ST_IDLE) || (state_d == ST_RUN); // RULE16
			row_overhead_time_o      <= seq_mode[OVH_MSB:OVH_LSB]; // RULE17
			zero_row_overhead_mode_o <= (seq_mode[OVH_MSB:OVH_LSB] == OVH_ZERO); // RULE17
			word_depth_8bit_o        <= depth[BIT_DEPTH_8];
		end
	end
	assign state_o = state_q;

	// ==========================================================
	// Checks
	a_reset_stby1: assert property (@(posedge clk_i) // RULE4
		$rose(rstn_i) |-> state_q == ST_STBY1)
		else $error("state not standby one after reset");

	a_early_wr_drop: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE5
		!wait_done |-> wr_en == '0)
		else $error("write accepted before reset wait");

	a_wait_len: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE5
		$rose(wait_done) |-> wait_q == RST_WAIT_W'(WAIT_CYC) && !$past(wait_done))
		else $error("reset wait length wrong");

	a_stby1_window: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE15
		ce_i && in_stby1 && wr_valid && wr.addr >= ADDR_STBY1_LIM |=> $stable(written_q))
		else $error("high register written in standby one");

	a_mode_keeps: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE2
		ce_i && state_q == ST_RUN && seq_wr && wr.data[BIT_ENABLE] && powered
		|=> ##1 state_q == ST_RUN)
		else $error("mode write changed running state");

	a_seq_acquire: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE14
		ce_i && state_q == ST_IDLE && seq_on && powered |=> state_q == ST_RUN ##0 acquiring_o)
		else $error("sequencer enabled but not acquiring");

	a_stby2_off: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE16
		ce_i && state_q == ST_STBY2 && !powered |=> !blocks_enabled_o && !acquiring_o)
		else $error("blocks active in standby two");

	a_overhead_field: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE17
		ce_i && seq_wr |=> ##1 row_overhead_time_o == $past(wr.data[OVH_MSB:OVH_LSB], 2))
		else $error("row overhead field not reflected");

	c_reach_stby2: cover property (@(posedge clk_i) disable iff (!rstn_i)
		state_q == ST_INTER ##1 state_q == ST_STBY2);
	c_reach_run: cover property (@(posedge clk_i) disable iff (!rstn_i)
		state_q == ST_IDLE ##1 state_q == ST_RUN);
	c_zero_overhead: cover property (@(posedge clk_i) disable iff (!rstn_i)
		acquiring_o && zero_row_overhead_mode_o);
endmodule
`default_nettype wire

// File: sbs_host_model.sv
// Host controller model: issues whole serial register frames to the sensor.
// Assumes clk_i is the sensor clock; pins change on its falling edge only.
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model
	import sbs_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic spi_miso_i,
	output var logic  spi_cs_n_o,
	output var logic  spi_sck_o,
	output var logic  spi_mosi_o
);
	// ==========================================================
	// Idle bus: deselected, serial clock parked low
	initial begin
		spi_cs_n_o = 1'b1;
		spi_sck_o  = 1'b0;
		spi_mosi_o = 1'b0;
	end

	// ==========================================================
	// One frame, fully ended before the caller may start another
	task automatic frame(input logic [ADDR_W-1:0] a, input logic rw,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
		logic [SPI_FRAME_BITS-1:0] sh;
		sh = {a, rw, d};
		q = '0;
		@(negedge clk_i);
		spi_cs_n_o = 1'b0;
		for (int i = 0; i < SPI_FRAME_BITS; i++) begin
			spi_mosi_o = sh[SPI_FRAME_BITS-1-i];
			repeat (2) @(negedge clk_i);
			// Read bits settle at the first clock rise after each fall
			if (i >= SPI_HDR_BITS)
				q = {q[DATA_W-2:0], spi_miso_i};
			spi_sck_o = 1'b1;
			repeat (2) @(negedge clk_i);
			spi_sck_o = 1'b0;
		end
		repeat (2) @(negedge clk_i);
		spi_cs_n_o = 1'b1;
		// Released data line must not look like a held bit
		spi_mosi_o = ~spi_mosi_o;
		repeat (3) @(negedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: tb_sensor_bringup_sequencer.sv
// Self-checking bench: bring-up from hard reset to running and back.
// Assumes the host model drives the serial pins; WAIT_CYC is shortened.
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_bringup_sequencer
	import sbs_pkg::*;
;
	localparam int unsigned WAIT = 150;
	logic              clk_i;
	logic              rstn_i;
	logic              ce;
	wire logic         cs_n;
	wire logic         sck;
	wire logic         mosi;
	logic              miso;
	sbs_state_t        st;
	logic              acq;
	logic              blk;
	logic [1:0]        ovh;
	logic              zovh;
	logic              d8;
	logic [DATA_W-1:0] mirror [512];
	logic [DATA_W-1:0] q;
	logic [3:0]        cfg;
	sbs_wr_t           w;
	int                seed;
	int                n_mismatch;
	int                compares;

	// ==========================================================
	// Clock, design and host
	always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

	sbs_core #(.WAIT_CYC(WAIT)) u_sbs_core (
		.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .spi_cs_n_i(cs_n),
		.spi_sck_i(sck), .spi_mosi_i(mosi), .spi_miso_o(miso), .state_o(st),
		.acquiring_o(acq), .blocks_enabled_o(blk), .row_overhead_time_o(ovh),
		.zero_row_overhead_mode_o(zovh), .word_depth_8bit_o(d8));

	sbs_host_model u_sbs_host_model (
		.clk_i(clk_i), .spi_miso_i(miso), .spi_cs_n_o(cs_n),
		.spi_sck_o(sck), .spi_mosi_o(mosi));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Write; ok says whether the sensor should keep it
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic ok);
		u_sbs_host_model.frame(a, 1'b1, d, q);
		if (ok)
			mirror[a] = d;
	endtask

	task automatic outs(input sbs_state_t s, input logic [5:0] o);
		check(16'(st), 16'(s));
		check({10'h000, acq, blk, ovh, zovh, d8}, {10'h000, o});
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Upload table picked from the host configuration: [0] 8-bit,
	// [2] colour, [3] smaller frame, [1] zero row overhead
	function automatic sbs_wr_t upload(input int i);
		case (i)
			0: return '{9'h041, 16'h008B};
			1: return '{9'h042, 16'h53C8};
			2: return '{9'h043, 16'h8848};
			3: return '{9'h044, 16'h0086};
			4: return '{9'h080, 16'h4520};
			5: return '{9'h0CC, cfg[1] ? 16'h09E6 : 16'h09E5};
			6: return '{9'h0E0, 16'h3E04};
			7: return '{9'h0E1, 16'h6733};
			8: return '{ADDR_DEPTH, {2'b00, cfg[0], 13'h0000}};
			9: return '{9'h1BF, 16'h0BF1};
			10: return '{9'h1C0, 16'h0BC3};
			11: return '{9'h100, 16'h4708};
			12: return '{9'h101, cfg[3] ? 16'h0400 : 16'h0200};
			13: return '{9'h102, cfg[3] ? 16'h0FFF : 16'h11FF};
			14: return '{ADDR_CLK_MGMT, 16'h2003};
			15: return '{ADDR_BIAS_EN, 16'h0001};
			16: return '{ADDR_COL_MUX, 16'h0003};
			17: return '{ADDR_FRONT_END, 16'h0001};
			default: return '{ADDR_TX_EN, 16'h0007};
		endcase
	endfunction

	// ==========================================================
	// Hang guard
	initial begin
		#(CLK_PERIOD_NS * 40000);
		n_mismatch++;
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		clk_i = 1'b0;
		rstn_i = 1'b0;
		ce = 1'b1;
		seed = 81597;
		n_mismatch = 0;
		compares = 0;
		foreach (mirror[i])
			mirror[i] = REG_RESET;
		cfg = 4'($random(seed));
		repeat (2) @(negedge clk_i);
		// Clock already running when hard reset lets go
		rstn_i = 1'b1;
		outs(ST_STBY1, 6'h00);
		// Too soon after reset: dropped
		wr(ADDR_LOGIC_EN, 16'h0001, 1'b0);
		outs(ST_STBY1, 6'h00);
		repeat (WAIT) @(negedge clk_i);
		// Standby one: only addresses below the boundary, boundary itself dropped
		wr(ADDR_STBY1_LIM, 16'($random(seed)), 1'b0);
		wr(ADDR_BIAS_EN, 16'($random(seed)), 1'b0);
		wr(ADDR_VARIANT, {15'h0000, cfg[2]}, 1'b1);
		wr(ADDR_CLK_MGMT, 16'h2002, 1'b1);
		wr(ADDR_LOGIC_EN, 16'h0001, 1'b1);
		outs(ST_INTER, 6'h00);
		$display("test standby_one done");
		// Reserved uploads; standby two only after the last one
		for (int i = 0; i < 14; i++) begin
			check(16'(st), 16'(ST_INTER));
			w = upload(i);
			wr(w.addr, w.data, 1'b1);
		end
		outs(ST_STBY2, {5'h00, cfg[0]});
		// Every register readable, an unmapped one reads zero
		for (int i = 0; i <= NREG; i++) begin
			w.addr = (i == NREG) ? 9'h003 : REG_ADDR[i];
			u_sbs_host_model.frame(w.addr, 1'b0, 16'h0000, q);
			check(q, mirror[w.addr]);
		end
		$display("test upload done");
		// Soft power-up: idle only when all enables are set
		for (int i = 14; i < 19; i++) begin
			check({15'h0000, blk}, 16'h0000);
			w = upload(i);
			wr(w.addr, w.data, 1'b1);
		end
		outs(ST_IDLE, {2'b01, 3'b000, cfg[0]});
		// Sequencer in both overhead modes, then mode change while idle
		for (int m = 0; m < 2; m++) begin
			wr(ADDR_SEQ_MODE, m ? 16'h000D : 16'h0001, 1'b1);
			outs(ST_RUN, {2'b11, m ? 3'b111 : 3'b000, cfg[0]});
		end
		wr(ADDR_SEQ_MODE, 16'h000C, 1'b1);
		outs(ST_IDLE, {2'b01, 3'b111, cfg[0]});
		wr(ADDR_SEQ_MODE, 16'h0000, 1'b1);
		outs(ST_IDLE, {2'b01, 3'b000, cfg[0]});
		// Clock enable low: a whole frame goes unseen, nothing moves
		ce = 1'b0;
		wr(ADDR_SEQ_MODE, 16'h0001, 1'b0);
		ce = 1'b1;
		outs(ST_IDLE, {2'b01, 3'b000, cfg[0]});
		$display("test sequencer done");
		// Transmitters off drops back to standby two
		wr(ADDR_TX_EN, 16'h0000, 1'b1);
		outs(ST_STBY2, {5'h00, cfg[0]});
		// Second hard reset from standby two
		rstn_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rstn_i = 1'b1;
		outs(ST_STBY1, 6'h00);
		$display("test second_reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
